// ### pkg/sivc_pkg.sv
// Shared types and constants for the interrupt and two-variable calculation decoder.
// Assumes a single 40 MHz clock domain and byte-wide host frames.
package sivc_pkg;
	// Instruction numbers handled by this block
	localparam logic [7:0] OPC_INTERRUPT_ENABLE  = 8'h19;
	localparam logic [7:0] OPC_INTERRUPT_DISABLE = 8'h1A;
	localparam logic [7:0] OPC_HANDLER_DEFINE    = 8'h25;
	localparam logic [7:0] OPC_HANDLER_RETURN    = 8'h26;
	localparam logic [7:0] OPC_TWO_VAR_CALC      = 8'h28;
	// Interrupt number that addresses the global enable
	localparam logic [7:0] IRQ_GLOBAL            = 8'hFF;
	// Reply status codes
	localparam logic [7:0] ST_OK                 = 8'h64;
	localparam logic [7:0] ST_UNSUPPORTED        = 8'h02;
	// Frame geometry
	localparam int         FRAME_LEN             = 9;
	localparam int         IDX_ADDR              = 0;
	localparam int         IDX_OPC               = 1;
	localparam int         IDX_TYPE              = 2;
	localparam int         IDX_BANK              = 3;
	localparam int         IDX_VAL3              = 4;
	localparam int         IDX_SUM               = 8;
	localparam logic [3:0] CNT_LAST              = 4'h8;
	localparam logic [3:0] CNT_ZERO              = 4'h0;
	localparam logic [3:0] CNT_ONE               = 4'h1;

	// Two-variable operation codes
	typedef enum logic [3:0] {
		OP_ADD      = 4'h0,
		OP_SUB      = 4'h1,
		MULTIPLY_OP = 4'h2,
		OP_DIV      = 4'h3,
		REMAINDER_OP = 4'h4,
		OP_AND      = 4'h5,
		OP_OR       = 4'h6,
		OP_XOR      = 4'h7,
		OP_NOT      = 4'h8,
		OP_LOAD     = 4'h9,
		OP_SWAP     = 4'hA,
		OP_COMP     = 4'hB
	} sivc_aluop_t;

	// One decoded instruction, host or engine sourced
	typedef struct packed {
		logic [7:0]  opc;
		logic [7:0]  typ;
		logic [7:0]  bank;
		logic [31:0] value;
	} sivc_cmd_t;

	// Execution context saved at handler entry
	typedef struct packed {
		logic [31:0] acc;
		logic [31:0] x;
		logic [7:0]  flags;
		logic [31:0] pc;
	} sivc_ctx_t;

	// Result flags of a comparison
	typedef struct packed {
		logic zero;
		logic neg;
	} sivc_cmpf_t;
endpackage

// ### core/sivc_alu.sv
// Combinational arithmetic and logic unit for two-variable calculations.
// Assumes its inputs are stable for the cycle in which the result is taken.
`timescale 1ns/100ps
`default_nettype none
module sivc_alu
	import sivc_pkg::*;
(
	input  wire logic [3:0]  op,
	input  wire logic [31:0] a,
	input  wire logic [31:0] b,
	output logic      [31:0] res,
	output sivc_cmpf_t       cmpf
);
	logic [31:0] diff;

	// Difference feeds both subtraction and comparison
	assign diff = a - b;

	// Result selection; division by zero yields zero rather than trapping
	always_comb begin
		res = a;
		unique case (op)
			OP_ADD:       res = a + b;
			OP_SUB:       res = diff;
			MULTIPLY_OP:  res = a * b;
			OP_DIV:       res = (b == 32'h0) ? 32'h0 : $signed(a) / $signed(b);
			REMAINDER_OP: res = (b == 32'h0) ? 32'h0 : $signed(a) % $signed(b);
			OP_AND:       res = a & b;
			OP_OR:        res = a | b;
			OP_XOR:       res = a ^ b;
			OP_NOT:       res = ~b;
			OP_LOAD:      res = b;
			OP_SWAP:      res = b;
			default:      res = a;
		endcase
	end

	// Signed compare of first against second
	assign cmpf.zero = (diff == 32'h0);
	assign cmpf.neg  = ($signed(a) < $signed(b));
endmodule
`default_nettype wire

// ### core/sivc_core.sv
// Decoder and executor for interrupt control and two-variable calculation instructions.
// Assumes host bytes and engine requests come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module sivc_core
	import sivc_pkg::*;
#(
	parameter int         NIRQ        = 32,
	parameter int         NVAR        = 256,
	parameter logic [7:0] MODULE_ADDR = 8'h01,
	parameter logic [7:0] HOST_ADDR   = 8'h02
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              rx_valid,
	input  wire logic [7:0]        rx_data,
	output logic                   rx_ready_r,
	output logic                   tx_valid_r,
	output logic      [7:0]        tx_data_r,
	input  wire logic              tx_ready,
	input  wire logic              eng_valid,
	input  wire sivc_cmd_t         eng_cmd,
	output logic                   eng_ready_r,
	output logic                   eng_done_r,
	input  wire sivc_ctx_t         ctx_in,
	input  wire logic [NIRQ-1:0]   irq_pending,
	output logic                   irq_jump_r,
	output logic      [31:0]       irq_pc_r,
	output logic                   restore_r,
	output sivc_ctx_t              restore_ctx_r,
	output logic                   in_handler_r,
	output logic                   global_en_r,
	output sivc_cmpf_t             cmp_flags_r
);
	localparam int IW = $clog2(NIRQ);
	localparam int VW = $clog2(NVAR);

	typedef enum logic [1:0] {
		S_IDLE  = 2'b00,
		S_EXEC  = 2'b01,
		S_SWAP  = 2'b10,
		S_REPLY = 2'b11
	} sivc_state_t;

	sivc_state_t      state_r, state_nxt;
	sivc_cmd_t        cmd_r, cmd_nxt;
	logic             host_r, host_nxt;
	logic [3:0]       rx_cnt_r, rx_cnt_nxt;
	logic             full_r, full_nxt;
	logic [7:0]       rx_buf_r [FRAME_LEN];
	logic [7:0]       tx_buf_r [FRAME_LEN];
	logic [3:0]       tx_cnt_r, tx_cnt_nxt;
	logic [NIRQ-1:0]  irq_en_r, irq_en_nxt;
	logic [31:0]      vec_mem [NIRQ];
	logic [31:0]      var_mem [NVAR];
	sivc_ctx_t        saved_r, saved_nxt;
	logic [31:0]      swap_r, swap_nxt;
	logic [7:0]       status_r, status_nxt;
	logic             rx_ready_nxt, tx_valid_nxt, eng_ready_nxt, eng_done_nxt;
	logic [7:0]       tx_data_nxt;
	logic             irq_jump_nxt, restore_nxt, in_handler_nxt, global_en_nxt;
	logic [31:0]      irq_pc_nxt;
	sivc_ctx_t        restore_ctx_nxt;
	sivc_cmpf_t       cmp_flags_nxt, alu_cmpf;
	logic             var_we, vec_we, rx_we, tx_load;
	logic [VW-1:0]    var_wa;
	logic [IW-1:0]    vec_wa;
	logic [31:0]      var_wd, vec_wd, alu_res, var_a, var_b;
	logic [7:0]       rx_sum;
	logic             frame_ok, fin;
	logic [NIRQ-1:0]  irq_hit;
	logic [IW-1:0]    irq_sel;
	logic             irq_any;

	// Interrupt number in range of the implemented set
	function automatic logic irq_valid(input logic [7:0] n);
		irq_valid = ({24'h0, n} < NIRQ);
	endfunction

	// Operands read straight from the variable store
	assign var_a = var_mem[cmd_r.bank[VW-1:0]];
	assign var_b = var_mem[cmd_r.value[VW-1:0]];

	sivc_alu u_alu (
		.op   (cmd_r.typ[3:0]),
		.a    (var_a),
		.b    (var_b),
		.res  (alu_res),
		.cmpf (alu_cmpf)
	);

	// Frame sum over the eight bytes before the checksum
	always_comb begin
		rx_sum = 8'h0;
		for (int i = 0; i < IDX_SUM; i++) begin
			rx_sum = rx_sum + rx_buf_r[i];
		end
	end
	assign frame_ok = (rx_sum == rx_buf_r[IDX_SUM]) && (rx_buf_r[IDX_ADDR] == MODULE_ADDR);

	// Lowest numbered interrupt that is pending and enabled wins
	assign irq_hit = irq_pending & irq_en_r & {NIRQ{global_en_r}};
	always_comb begin
		irq_sel = '0;
		irq_any = 1'b0;
		for (int i = NIRQ - 1; i >= 0; i--) begin
			if (irq_hit[i]) begin
				irq_sel = IW'(i);
				irq_any = 1'b1;
			end
		end
	end

	// Next-state logic for sequencing, decode and execution
	always_comb begin
		state_nxt       = state_r;
		cmd_nxt         = cmd_r;
		host_nxt        = host_r;
		rx_cnt_nxt      = rx_cnt_r;
		full_nxt        = full_r;
		tx_cnt_nxt      = tx_cnt_r;
		irq_en_nxt      = irq_en_r;
		saved_nxt       = saved_r;
		swap_nxt        = swap_r;
		status_nxt      = status_r;
		tx_valid_nxt    = tx_valid_r;
		tx_data_nxt     = tx_data_r;
		eng_done_nxt    = 1'b0;
		irq_jump_nxt    = 1'b0;
		irq_pc_nxt      = irq_pc_r;
		restore_nxt     = 1'b0;
		restore_ctx_nxt = restore_ctx_r;
		in_handler_nxt  = in_handler_r;
		global_en_nxt   = global_en_r;
		cmp_flags_nxt   = cmp_flags_r;
		var_we = 1'b0;
		var_wa = cmd_r.bank[VW-1:0];
		var_wd = alu_res;
		vec_we = 1'b0;
		vec_wa = cmd_r.typ[IW-1:0];
		vec_wd = cmd_r.value;
		rx_we   = 1'b0;
		tx_load = 1'b0;
		fin     = 1'b0;
		// Byte collection; the ninth byte closes the frame
		if (rx_valid && rx_ready_r) begin
			rx_we = 1'b1;
			rx_cnt_nxt = (rx_cnt_r == CNT_LAST) ? CNT_ZERO : rx_cnt_r + CNT_ONE;
			full_nxt = (rx_cnt_r == CNT_LAST);
		end
		unique case (state_r)
			S_IDLE: begin
				if (eng_valid && eng_ready_r) begin
					cmd_nxt = eng_cmd;
					host_nxt = 1'b0;
					state_nxt = S_EXEC;
				end else if (full_r) begin
					// Bad sum or foreign address is dropped without a reply
					full_nxt = 1'b0;
					if (frame_ok) begin
						cmd_nxt = {rx_buf_r[IDX_OPC], rx_buf_r[IDX_TYPE], rx_buf_r[IDX_BANK],
							rx_buf_r[IDX_VAL3], rx_buf_r[IDX_VAL3+1], rx_buf_r[IDX_VAL3+2],
							rx_buf_r[IDX_VAL3+3]};
						host_nxt = 1'b1;
						state_nxt = S_EXEC;
					end
				end else if (irq_any && !in_handler_r && eng_ready_r) begin
					saved_nxt = ctx_in;
					irq_pc_nxt = vec_mem[irq_sel];
					irq_jump_nxt = 1'b1;
					in_handler_nxt = 1'b1;
				end
			end
			S_EXEC: begin
				fin = 1'b1;
				status_nxt = ST_OK;
				unique case (cmd_r.opc)
					OPC_INTERRUPT_ENABLE: begin
						if (cmd_r.typ == IRQ_GLOBAL) global_en_nxt = 1'b1;
						else if (irq_valid(cmd_r.typ)) irq_en_nxt[cmd_r.typ[IW-1:0]] = 1'b1;
					end
					OPC_INTERRUPT_DISABLE: begin
						if (cmd_r.typ == IRQ_GLOBAL) global_en_nxt = 1'b0;
						else if (irq_valid(cmd_r.typ)) irq_en_nxt[cmd_r.typ[IW-1:0]] = 1'b0;
					end
					OPC_HANDLER_DEFINE: begin
						vec_we = irq_valid(cmd_r.typ);
					end
					OPC_HANDLER_RETURN: begin
						// Outside a handler there is nothing to resume
						if (in_handler_r) begin
							restore_nxt = 1'b1;
							restore_ctx_nxt = saved_r;
							in_handler_nxt = 1'b0;
						end
					end
					OPC_TWO_VAR_CALC: begin
						if (cmd_r.typ[3:0] == OP_COMP && cmd_r.typ[7:4] == 4'h0) begin
							cmp_flags_nxt = alu_cmpf;
						end else if (cmd_r.typ < 8'h0C) begin
							var_we = 1'b1;
							if (cmd_r.typ[3:0] == OP_SWAP) begin
								swap_nxt = var_a;
								fin = 1'b0;
								state_nxt = S_SWAP;
							end
						end else begin
							status_nxt = ST_UNSUPPORTED;
						end
					end
					default: status_nxt = ST_UNSUPPORTED;
				endcase
			end
			S_SWAP: begin
				// Second half of the exchange; the first write already landed
				var_we = 1'b1;
				var_wa = cmd_r.value[VW-1:0];
				var_wd = swap_r;
				fin = 1'b1;
			end
			S_REPLY: begin
				if (tx_valid_r && tx_ready) begin
					if (tx_cnt_r == CNT_LAST) begin
						tx_valid_nxt = 1'b0;
						state_nxt = S_IDLE;
					end else begin
						tx_cnt_nxt = tx_cnt_r + CNT_ONE;
						tx_data_nxt = tx_buf_r[tx_cnt_r + CNT_ONE];
					end
				end
			end
		endcase
		// Completion: host commands answer with a frame, engine ones with a pulse
		if (fin) begin
			if (host_r) begin
				tx_load = 1'b1;
				tx_cnt_nxt = CNT_ZERO;
				tx_valid_nxt = 1'b1;
				tx_data_nxt = HOST_ADDR;
				state_nxt = S_REPLY;
			end else begin
				eng_done_nxt = 1'b1;
				state_nxt = S_IDLE;
			end
		end
		// Host waits while a complete frame is unconsumed; engine waits while busy
		rx_ready_nxt  = !full_nxt;
		eng_ready_nxt = (state_nxt == S_IDLE) && !full_nxt;
	end

	// Storage of control state and registered outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r       <= S_IDLE;
			cmd_r         <= '0;
			host_r        <= 1'b0;
			rx_cnt_r      <= CNT_ZERO;
			full_r        <= 1'b0;
			tx_cnt_r      <= CNT_ZERO;
			irq_en_r      <= '0;
			saved_r       <= '0;
			swap_r        <= '0;
			status_r      <= ST_OK;
			rx_ready_r    <= 1'b0;
			tx_valid_r    <= 1'b0;
			tx_data_r     <= 8'h00;
			eng_ready_r   <= 1'b0;
			eng_done_r    <= 1'b0;
			irq_jump_r    <= 1'b0;
			irq_pc_r      <= '0;
			restore_r     <= 1'b0;
			restore_ctx_r <= '0;
			in_handler_r  <= 1'b0;
			global_en_r   <= 1'b0;
			cmp_flags_r   <= '0;
		end else begin
			state_r       <= state_nxt;
			cmd_r         <= cmd_nxt;
			host_r        <= host_nxt;
			rx_cnt_r      <= rx_cnt_nxt;
			full_r        <= full_nxt;
			tx_cnt_r      <= tx_cnt_nxt;
			irq_en_r      <= irq_en_nxt;
			saved_r       <= saved_nxt;
			swap_r        <= swap_nxt;
			status_r      <= status_nxt;
			rx_ready_r    <= rx_ready_nxt;
			tx_valid_r    <= tx_valid_nxt;
			tx_data_r     <= tx_data_nxt;
			eng_ready_r   <= eng_ready_nxt;
			eng_done_r    <= eng_done_nxt;
			irq_jump_r    <= irq_jump_nxt;
			irq_pc_r      <= irq_pc_nxt;
			restore_r     <= restore_nxt;
			restore_ctx_r <= restore_ctx_nxt;
			in_handler_r  <= in_handler_nxt;
			global_en_r   <= global_en_nxt;
			cmp_flags_r   <= cmp_flags_nxt;
		end
	end

	// Variables clear on reset so every calculation starts from defined values;
	// frame buffers and vectors carry no reset, they are written before being read
	always_ff @(posedge clk) begin
		if (rx_we) rx_buf_r[rx_cnt_r] <= rx_data;
		if (rst) begin
			for (int i = 0; i < NVAR; i++) var_mem[i] <= '0;
		end else if (var_we) begin
			var_mem[var_wa] <= var_wd;
		end
		if (vec_we) vec_mem[vec_wa] <= vec_wd;
		if (tx_load) begin
			tx_buf_r[0] <= HOST_ADDR;
			tx_buf_r[1] <= MODULE_ADDR;
			tx_buf_r[2] <= status_nxt;
			tx_buf_r[3] <= cmd_r.opc;
			for (int i = 4; i < IDX_SUM; i++) tx_buf_r[i] <= 8'h00;
			tx_buf_r[IDX_SUM] <= HOST_ADDR + MODULE_ADDR + status_nxt + cmd_r.opc;
		end
	end
endmodule
`default_nettype wire

// ### sim/sivc_host.sv
// Host model: sends nine-byte command frames and gathers the reply bytes.
// Assumes the block's byte handshakes run on the same clock as this model.
`timescale 1ns/100ps
`default_nettype none
module sivc_host
	import sivc_pkg::*;
(
	input  wire logic       clk,
	output logic            rx_valid,
	output logic      [7:0] rx_data,
	input  wire logic       rx_ready_r,
	input  wire logic       tx_valid_r,
	input  wire logic [7:0] tx_data_r,
	output logic            tx_ready
);
	logic       slow = 1'h0;
	logic [7:0] rep[$];
	initial begin
		rx_valid = 1'h0;
		rx_data  = 8'h00;
		tx_ready = 1'h1;
	end
	// Slow mode takes a reply byte only every other cycle, to stress the hold
	always @(negedge clk) tx_ready <= slow ? ~tx_ready : 1'h1;
	// Reply bytes in arrival order
	always @(posedge clk) if (tx_valid_r && tx_ready) rep.push_back(tx_data_r);
	// One whole frame, value MSB first; bad flips the lowest bit of the checksum
	task automatic send(input logic [7:0] adr, opc, typ, bank, input logic [31:0] val,
		input logic bad);
		logic [7:0] f[9];
		f = '{adr, opc, typ, bank, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
		for (int i = 0; i < 8; i++) f[8] += f[i];
		f[8] ^= {7'h00, bad};
		for (int i = 0; i < 9; i++) begin
			@(negedge clk);
			rx_valid = 1'h1;
			rx_data  = f[i];
			while (!rx_ready_r) @(negedge clk);
			@(posedge clk);
		end
		@(negedge clk);
		rx_valid = 1'h0;
		rx_data  = ~rx_data; // Released line must not repeat the last byte
	endtask
endmodule
`default_nettype wire

// ### sim/sivc_core_sva.sv
// Port checker for the interrupt and calculation decoder.
// Assumes it is bound into sivc_core by the bind at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module sivc_core_sva
	import sivc_pkg::*;
#(
	parameter int         NIRQ      = 32,
	parameter logic [7:0] HOST_ADDR = 8'h02
) (
	input wire logic            clk,
	input wire logic            rst,
	input wire logic            tx_valid_r,
	input wire logic [7:0]      tx_data_r,
	input wire logic            tx_ready,
	input wire logic            eng_valid,
	input wire sivc_cmd_t       eng_cmd,
	input wire logic            eng_ready_r,
	input wire logic            eng_done_r,
	input wire sivc_ctx_t       ctx_in,
	input wire logic [NIRQ-1:0] irq_pending,
	input wire logic            irq_jump_r,
	input wire logic            restore_r,
	input wire sivc_ctx_t       restore_ctx_r,
	input wire logic            in_handler_r,
	input wire logic            global_en_r
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic      take;
	logic      pend_any;
	sivc_ctx_t prev_r;
	sivc_ctx_t saved_r;
	assign take     = eng_valid && eng_ready_r;
	assign pend_any = |irq_pending;
	// Shadow of the context the block must save; prev_r is ctx_in at the entry edge
	always_ff @(posedge clk) begin
		prev_r <= ctx_in;
		if (irq_jump_r) begin
			saved_r <= prev_r;
		end
	end
	chk_global_set: assert property (take && eng_cmd.opc == OPC_INTERRUPT_ENABLE
		&& eng_cmd.typ == IRQ_GLOBAL |-> ##[1:3] global_en_r) else $error("global not set");
	chk_global_clr: assert property (take && eng_cmd.opc == OPC_INTERRUPT_DISABLE
		&& eng_cmd.typ == IRQ_GLOBAL |-> ##[1:3] !global_en_r) else $error("global not clear");
	chk_eng_answer: assert property (take |=> !eng_ready_r ##[1:2] eng_done_r)
		else $error("engine answer late");
	chk_entry_cause: assert property (irq_jump_r |-> $past(global_en_r)
		&& $past(pend_any) && !$past(in_handler_r)) else $error("entry without cause");
	chk_entry_state: assert property (irq_jump_r |=> in_handler_r && !irq_jump_r)
		else $error("handler state wrong");
	chk_return_ctx: assert property (restore_r |-> restore_ctx_r == saved_r)
		else $error("restored context wrong");
	chk_return_exit: assert property (restore_r |-> $past(in_handler_r)
		##[0:1] !in_handler_r) else $error("handler not left");
	chk_reply_head: assert property ($rose(tx_valid_r) |-> tx_data_r == HOST_ADDR)
		else $error("reply head wrong");
	chk_reply_hold: assert property (tx_valid_r && !tx_ready |=> tx_valid_r
		&& $stable(tx_data_r)) else $error("reply byte dropped");
	cover property (irq_jump_r);
	cover property (restore_r);
	cover property (tx_valid_r && !tx_ready);
endmodule
bind sivc_core sivc_core_sva #(.NIRQ(NIRQ), .HOST_ADDR(HOST_ADDR)) u_sva (
	.clk(clk), .rst(rst), .tx_valid_r(tx_valid_r), .tx_data_r(tx_data_r),
	.tx_ready(tx_ready), .eng_valid(eng_valid), .eng_cmd(eng_cmd),
	.eng_ready_r(eng_ready_r), .eng_done_r(eng_done_r), .ctx_in(ctx_in),
	.irq_pending(irq_pending), .irq_jump_r(irq_jump_r), .restore_r(restore_r),
	.restore_ctx_r(restore_ctx_r), .in_handler_r(in_handler_r), .global_en_r(global_en_r)
);
`default_nettype wire

// ### sim/sivc_core_tb.sv
// Testbench for the interrupt and two-variable calculation decoder.
// Assumes the host model and the bound checker; variables clear on reset, so
// calculation results are judged by replies and by the compare flags.
`timescale 1ns/100ps
`default_nettype none
module sivc_core_tb
	import sivc_pkg::*;
;
	localparam logic [7:0] ADR = 8'h01;
	localparam logic [7:0] HST = 8'h02;
	logic clk, rst, rx_valid, rx_ready_r, tx_valid_r, tx_ready, eng_valid, eng_ready_r;
	logic eng_done_r, irq_jump_r, restore_r, in_handler_r, global_en_r;
	logic [7:0] rx_data, tx_data_r;
	logic [31:0] irq_pending, irq_pc_r;
	sivc_cmd_t eng_cmd;
	sivc_ctx_t ctx_in, restore_ctx_r, ctx;
	sivc_cmpf_t cmp_flags_r;
	int fails = 0;
	int cmp_count = 0;
	int cyc = 0;
	sivc_core #(.MODULE_ADDR(ADR), .HOST_ADDR(HST)) uut (.clk(clk), .rst(rst),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_ready_r(rx_ready_r),
		.tx_valid_r(tx_valid_r), .tx_data_r(tx_data_r), .tx_ready(tx_ready),
		.eng_valid(eng_valid), .eng_cmd(eng_cmd), .eng_ready_r(eng_ready_r),
		.eng_done_r(eng_done_r), .ctx_in(ctx_in), .irq_pending(irq_pending),
		.irq_jump_r(irq_jump_r), .irq_pc_r(irq_pc_r), .restore_r(restore_r),
		.restore_ctx_r(restore_ctx_r), .in_handler_r(in_handler_r),
		.global_en_r(global_en_r), .cmp_flags_r(cmp_flags_r));
	sivc_host u_host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_ready_r(rx_ready_r), .tx_valid_r(tx_valid_r), .tx_data_r(tx_data_r),
		.tx_ready(tx_ready));
	always #12.5 clk = ~clk;
	task automatic test_done;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// A hang counts as a mismatch
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			test_done;
		end
	end
	task automatic chk(input logic [103:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Engine request held until taken, then a bounded wait for done
	task automatic eng(input logic [7:0] opc, typ, input logic [31:0] val);
		int n;
		@(negedge clk);
		eng_valid = 1'h1;
		eng_cmd   = '{opc, typ, 8'h00, val};
		while (!eng_ready_r) @(negedge clk);
		@(posedge clk);
		@(negedge clk);
		eng_valid = 1'h0;
		n = 0;
		while (!eng_done_r && n < 6) begin
			@(negedge clk);
			n++;
		end
		chk(eng_done_r, 1'h1);
	endtask
	// Host frame and its reply; st 00h means the frame must be dropped
	task automatic frame(input logic [7:0] adr, opc, typ, bank, input logic [31:0] val,
		input logic bad, input logic [7:0] st);
		logic [7:0] e[9];
		int n;
		e = '{HST, ADR, st, opc, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		e[8] = HST + ADR + st + opc;
		u_host.rep.delete();
		u_host.send(adr, opc, typ, bank, val, bad);
		n = 0;
		while (u_host.rep.size() < 9 && n < 30) begin
			@(negedge clk);
			n++;
		end
		if (st == 8'h00) chk(u_host.rep.size(), 0);
		else for (int i = 0; i < 9; i++) chk(u_host.rep[i], e[i]);
	endtask
	task automatic wait_jump(input logic hit, input logic [31:0] pc);
		int n;
		n = 0;
		while (!irq_jump_r && n < 8) begin
			@(negedge clk);
			n++;
		end
		chk(irq_jump_r, hit);
		if (hit) chk(irq_pc_r, pc);
	endtask
	// One operation on variables 41h and 2Ah, then a compare judged by its flags
	task automatic calc_cmp(input logic [7:0] op, input logic [1:0] fl);
		frame(ADR, OPC_TWO_VAR_CALC, op, 8'h41, 32'h2A, 1'h0, ST_OK);
		frame(ADR, OPC_TWO_VAR_CALC, 8'h0B, 8'h41, 32'h2A, 1'h0, ST_OK);
		chk(cmp_flags_r, fl);
	endtask
	// Refused frames, then global enable and disable from the host under stalls
	task automatic t_drop;
		frame(ADR, OPC_INTERRUPT_ENABLE, IRQ_GLOBAL, 8'h00, 0, 1'h1, 8'h00);
		frame(8'h05, OPC_INTERRUPT_ENABLE, IRQ_GLOBAL, 8'h00, 0, 1'h0, 8'h00);
		u_host.slow = 1'h1;
		frame(ADR, OPC_INTERRUPT_ENABLE, IRQ_GLOBAL, 8'h00, 0, 1'h0, ST_OK);
		chk(global_en_r, 1'h1);
		frame(ADR, OPC_INTERRUPT_DISABLE, IRQ_GLOBAL, 8'h00, 0, 1'h0, ST_OK);
		chk(global_en_r, 1'h0);
		u_host.slow = 1'h0;
	endtask
	// Every operation code by host frame, one past the last, and engine timing
	task automatic t_calc;
		for (int op = 0; op < 12; op++) begin
			frame(ADR, OPC_TWO_VAR_CALC, op[7:0], 8'h41, 32'h2A, 1'h0, ST_OK);
		end
		frame(ADR, OPC_TWO_VAR_CALC, 8'h0C, 8'h41, 32'h2A, 1'h0, ST_UNSUPPORTED);
		// Both variables are back to zero, so the last compare saw them equal
		chk(cmp_flags_r, 2'b10);
		// Flags are {zero, neg}: var41 = ~0 is below zero
		calc_cmp(8'h08, 2'b01);
		// Exchange leaves var41 = 0 above var2A = -1
		calc_cmp(8'h0A, 2'b00);
		// 0 + -1 equals var2A
		calc_cmp(8'h00, 2'b10);
		// -1 - -1 gives 0, above var2A
		calc_cmp(8'h01, 2'b00);
		// Copy makes both equal again
		calc_cmp(8'h09, 2'b10);
		eng(OPC_TWO_VAR_CALC, 8'h0A, 32'h2A);
		eng(OPC_TWO_VAR_CALC, 8'h08, 32'h2A);
	endtask
	// Vectors, enables, entry and return with a changed live context
	task automatic t_irq;
		ctx = '{32'h11111111, 32'h22222222, 8'h33, 32'h44444444};
		ctx_in = ctx;
		eng(OPC_HANDLER_DEFINE, 8'h03, 32'h50);
		eng(OPC_HANDLER_DEFINE, 8'h03, 32'h60);
		eng(OPC_HANDLER_DEFINE, 8'h01, 32'h70);
		eng(OPC_INTERRUPT_ENABLE, 8'h03, 0);
		irq_pending[3] = 1'h1;
		wait_jump(1'h0, 0);
		eng(OPC_INTERRUPT_ENABLE, IRQ_GLOBAL, 0);
		wait_jump(1'h1, 32'h60);
		@(negedge clk);
		chk(in_handler_r, 1'h1);
		ctx_in = ~ctx;
		irq_pending = 0;
		eng(OPC_HANDLER_RETURN, 8'h00, 0);
		chk(restore_ctx_r, ctx);
		chk(in_handler_r, 1'h0);
		eng(OPC_INTERRUPT_DISABLE, 8'h03, 0);
		irq_pending[3] = 1'h1;
		wait_jump(1'h0, 0);
		eng(OPC_INTERRUPT_ENABLE, 8'h01, 0);
		irq_pending[1] = 1'h1;
		wait_jump(1'h1, 32'h70);
		irq_pending = 0;
		eng(OPC_HANDLER_RETURN, 8'h00, 0);
		eng(OPC_INTERRUPT_DISABLE, IRQ_GLOBAL, 0);
		irq_pending[1] = 1'h1;
		wait_jump(1'h0, 0);
		irq_pending = 0;
	endtask
	initial begin
		clk = 1'h0;
		rst = 1'h1;
		eng_valid = 1'h0;
		eng_cmd = '0;
		ctx_in = '0;
		irq_pending = 0;
		repeat (12) @(negedge clk);
		rst = 1'h0;
		repeat (2) @(negedge clk);
		t_drop;
		t_calc;
		t_irq;
		test_done;
	end
endmodule
`default_nettype wire
